/* File: design/xcore.sv */
// Execution core for zero test, XOR and extended pointer instructions.
`timescale 1ns/1ps
`default_nettype none
module xcore
  import xcore_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        NRST,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output var  logic        PREADY,
  output var  logic [31:0] PRDATA,
  output var  logic        PSLVERR
);
  import xcore_pkg::*;

  logic [7:0]  mem [0:4095];
  core_state_t state, next_state;
  logic [1:0]  stall, next_stall;
  logic        ext_en, next_ext_en;
  logic [15:0] iword, next_iword, word1, next_word1;
  logic [7:0]  acc, next_acc, bank_sel, next_bank_sel;
  logic        flag_n, next_flag_n, flag_z, next_flag_z;
  logic [11:0] fsr0, next_fsr0, fsr1, next_fsr1;
  logic [11:0] stack_ptr, next_stack_ptr;
  logic [20:0] pc, next_pc, ret_top, next_ret_top;
  logic [7:0]  pclath, next_pclath;
  logic [4:0]  pclatu, next_pclatu;
  logic [31:0] cyc, next_cyc;
  logic [11:0] maddr, next_maddr;
  logic        skip, next_skip, skip2, next_skip2;
  logic        second, next_second;
  logic        pready_q, next_pready;
  logic [31:0] prdata_q, next_prdata;
  logic        pslverr_q, next_pslverr;
  mem_wr_t     wr;
  logic [11:0] rd_addr;
  logic [7:0]  rd_data, res;
  logic        access, issue, mapped;
  op_t         op;

  function automatic op_t decode(input logic [15:0] w, input logic ext);
    op_t o;
    o = OP_NOP;
    if (w[15:9] == OPC_TST)
      o = OP_TST;
    else if (w[15:8] == OPC_XOR_LIT)
      o = OP_XOR_LIT;
    else if (w[15:10] == OPC_XOR_FILE)
      o = OP_XOR_FILE;
    else if (ext) // RL10 RL19
    begin
      if (w == OPC_CALL_ACC)
        o = OP_CALL_ACC; // RL14
      else if (w[15:8] == OPC_ADDP)
        o = OP_ADDP;
      else if (w[15:8] == OPC_SUBP)
        o = OP_SUBP;
      else if (w[15:8] == OPC_PUSH_LIT)
        o = OP_PUSH_LIT;
      else if (w[15:8] == OPC_MOV)
        o = OP_MOV1; // RL15
    end
    return o;
  endfunction

  // Operand address of a byte-oriented instruction.
  function automatic logic [11:0] file_addr(input logic a,
      input logic [7:0] f, input logic [7:0] b, input logic ext,
      input logic [11:0] sp);
    logic [11:0] r;
    r = {ACCESS_HI, f};
    if (a)
      r = {b[3:0], f}; // RL3
    else if (f <= ACCESS_LIM && ext)
      r = sp + {4'h0, f}; // RL4
    else if (f <= ACCESS_LIM)
      r = {4'h0, f}; // RL3 RL19
    return r;
  endfunction

  function automatic logic is_word1(input logic [15:0] w, input logic ext);
    return ext && (w[15:8] == OPC_MOV);
  endfunction

  assign access = PSEL && PENABLE && !pready_q;
  assign issue = access && PWRITE && (PADDR == OFF_IWORD)
                 && (state == S_READY);
  assign op = decode(PWDATA[15:0], ext_en);
  assign rd_data = mem[rd_addr];

  always_comb
  begin
    next_state = state;
    next_stall = stall;
    next_ext_en = ext_en;
    next_iword = iword;
    next_word1 = word1;
    next_acc = acc;
    next_bank_sel = bank_sel;
    next_flag_n = flag_n;
    next_flag_z = flag_z;
    next_fsr0 = fsr0;
    next_fsr1 = fsr1;
    next_stack_ptr = stack_ptr;
    next_pc = pc;
    next_ret_top = ret_top;
    next_pclath = pclath;
    next_pclatu = pclatu;
    next_cyc = cyc;
    next_maddr = maddr;
    next_skip = skip;
    next_skip2 = skip2;
    next_second = second;
    wr = '0;
    res = '0;
    rd_addr = maddr;
    unique case (state)
      S_READY:
        ;
      S_STALL:
      begin
        // Extra cycles run as full no-operations.
        next_cyc = cyc + 32'h0000_0001;
        next_stall = stall - 2'h1;
        if (stall == 2'h1)
          next_state = S_READY;
      end
    endcase
    if (issue)
    begin
      next_iword = PWDATA[15:0];
      next_cyc = cyc + 32'h0000_0001;
      next_pc = pc + PC_STEP;
      if (second)
      begin
        next_second = 1'b0;
        next_skip2 = 1'b0;
        if (!skip2 && PWDATA[15:12] == OPC_WORD2)
        begin
          // RL15
          rd_addr = stack_ptr + {5'h00, word1[6:0]};
          wr.we = 1'b1;
          wr.data = rd_data;
          wr.addr = word1[7] ? stack_ptr + {5'h00, PWDATA[6:0]}
                             : PWDATA[11:0];
        end
      end
      else if (skip)
      begin
        // RL1 RL2
        next_skip = 1'b0;
        if (is_word1(PWDATA[15:0], ext_en))
        begin
          next_second = 1'b1;
          next_skip2 = 1'b1;
        end
      end
      else
      begin
        rd_addr = file_addr(PWDATA[8], PWDATA[7:0], bank_sel, ext_en,
                            stack_ptr);
        unique case (op)
          OP_NOP:
            ;
          OP_TST:
            next_skip = (rd_data == 8'h00); // RL1 RL5
          OP_XOR_LIT, OP_XOR_FILE:
          begin
            res = acc ^ (op == OP_XOR_LIT ? PWDATA[7:0] : rd_data); // RL6
            next_flag_n = res[7]; // RL9
            next_flag_z = (res == 8'h00); // RL9
            if (op == OP_XOR_FILE && PWDATA[9])
            begin
              wr.we = 1'b1; // RL7 RL8
              wr.addr = rd_addr;
              wr.data = res;
            end
            else
              next_acc = res; // RL6 RL7
          end
          OP_ADDP, OP_SUBP:
          begin
            unique case (PWDATA[7:6]) // RL11
              2'h0:
                next_fsr0 = op == OP_ADDP ? fsr0 + {6'h00, PWDATA[5:0]}
                                          : fsr0 - {6'h00, PWDATA[5:0]};
              2'h1:
                next_fsr1 = op == OP_ADDP ? fsr1 + {6'h00, PWDATA[5:0]}
                                          : fsr1 - {6'h00, PWDATA[5:0]};
              default:
                next_stack_ptr = op == OP_ADDP
                                 ? stack_ptr + {6'h00, PWDATA[5:0]}
                                 : stack_ptr - {6'h00, PWDATA[5:0]};
            endcase
            if (PWDATA[7:6] == SEL_STACK)
            begin
              next_pc = ret_top; // RL12 RL13 RL17
              next_stall = EXTRA_TWO;
              next_state = S_STALL;
            end
          end
          OP_CALL_ACC:
          begin
            next_ret_top = pc + PC_STEP; // RL18
            next_pc = {pclatu, pclath, acc}; // RL18
            next_stall = EXTRA_TWO; // RL14
            next_state = S_STALL;
          end
          OP_MOV1:
          begin
            next_word1 = PWDATA[15:0];
            next_second = 1'b1;
          end
          OP_PUSH_LIT:
          begin
            wr.we = 1'b1; // RL16
            wr.addr = stack_ptr;
            wr.data = PWDATA[7:0];
            next_stack_ptr = stack_ptr - 12'h001; // RL16
          end
        endcase
      end
    end
    else if (access && PWRITE)
    begin
      unique case (PADDR)
        OFF_CTRL:   next_ext_en = PWDATA[0]; // RL10
        OFF_ACC:    next_acc = PWDATA[7:0];
        OFF_STATUS:
        begin
          next_flag_n = PWDATA[N_BIT];
          next_flag_z = PWDATA[Z_BIT];
        end
        OFF_BANK:   next_bank_sel = {4'h0, PWDATA[3:0]};
        OFF_FSR0:   next_fsr0 = PWDATA[11:0];
        OFF_FSR1:   next_fsr1 = PWDATA[11:0];
        OFF_SPTR:   next_stack_ptr = PWDATA[11:0];
        OFF_PC:     next_pc = {PWDATA[20:1], 1'b0};
        OFF_RTOP:   next_ret_top = PWDATA[20:0];
        OFF_LATCH:
        begin
          next_pclath = PWDATA[7:0];
          next_pclatu = PWDATA[12:8];
        end
        OFF_MADDR:  next_maddr = PWDATA[11:0];
        OFF_MDATA:
        begin
          wr.we = 1'b1;
          wr.addr = maddr;
          wr.data = PWDATA[7:0];
        end
        default:
          ;
      endcase
    end
  end

  // An instruction write waits in the access phase while the core stalls.
  always_comb
  begin
    mapped = (PADDR <= OFF_CORE) && (PADDR[1:0] == 2'h0);
    next_pready = access && (state == S_READY || PADDR != OFF_IWORD);
    next_pslverr = next_pready && !mapped;
    next_prdata = '0;
    if (next_pready && !PWRITE)
    begin
      unique case (PADDR)
        OFF_CTRL:   next_prdata = {31'h0000_0000, ext_en};
        OFF_IWORD:  next_prdata = {16'h0000, iword};
        OFF_ACC:    next_prdata = {24'h00_0000, acc};
        OFF_STATUS: next_prdata = (32'(flag_n) << N_BIT)
                                  | (32'(flag_z) << Z_BIT);
        OFF_BANK:   next_prdata = {24'h00_0000, bank_sel};
        OFF_FSR0:   next_prdata = {20'h0_0000, fsr0};
        OFF_FSR1:   next_prdata = {20'h0_0000, fsr1};
        OFF_SPTR:   next_prdata = {20'h0_0000, stack_ptr};
        OFF_PC:     next_prdata = {11'h000, pc};
        OFF_RTOP:   next_prdata = {11'h000, ret_top};
        OFF_LATCH:  next_prdata = {19'h0_0000, pclatu, pclath};
        OFF_CYC:    next_prdata = cyc;
        OFF_MADDR:  next_prdata = {20'h0_0000, maddr};
        OFF_MDATA:  next_prdata = {24'h00_0000, rd_data};
        OFF_CORE:   next_prdata = {28'h000_0000, second, skip,
                                   state == S_STALL, 1'b0};
        default:    next_prdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLOCK)
  begin
    if (wr.we)
      mem[wr.addr] <= wr.data;
  end

  always_ff @(posedge CLOCK)
  begin
    if (!NRST)
    begin
      state <= S_READY;
      stall <= '0;
      ext_en <= CTRL_RST;
      iword <= '0;
      word1 <= '0;
      acc <= '0;
      bank_sel <= '0;
      flag_n <= 1'b0;
      flag_z <= 1'b0;
      fsr0 <= '0;
      fsr1 <= '0;
      stack_ptr <= '0;
      pc <= '0;
      ret_top <= '0;
      pclath <= '0;
      pclatu <= '0;
      cyc <= '0;
      maddr <= '0;
      skip <= 1'b0;
      skip2 <= 1'b0;
      second <= 1'b0;
      pready_q <= 1'b0;
      prdata_q <= '0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      state <= next_state;
      stall <= next_stall;
      ext_en <= next_ext_en;
      iword <= next_iword;
      word1 <= next_word1;
      acc <= next_acc;
      bank_sel <= next_bank_sel;
      flag_n <= next_flag_n;
      flag_z <= next_flag_z;
      fsr0 <= next_fsr0;
      fsr1 <= next_fsr1;
      stack_ptr <= next_stack_ptr;
      pc <= next_pc;
      ret_top <= next_ret_top;
      pclath <= next_pclath;
      pclatu <= next_pclatu;
      cyc <= next_cyc;
      maddr <= next_maddr;
      skip <= next_skip;
      skip2 <= next_skip2;
      second <= next_second;
      pready_q <= next_pready;
      prdata_q <= next_prdata;
      pslverr_q <= next_pslverr;
    end
  end

  assign PREADY = pready_q;
  assign PRDATA = prdata_q;
  assign PSLVERR = pslverr_q;
endmodule // xcore
`default_nettype wire

/* File: design/xcore_pkg.sv */
// Constants, types and register map of the instruction execution core.
// Notes on behaviour
// RL1: A zero test hit discards the next fetched word and runs a no-operation.
// RL2: Zero test takes one cycle, two when skipping, three over two-word ops.
// RL3: Bank bit 0 uses the access bank; bank bit 1 uses the bank select.
// RL4: Extension on, bank bit 0, operand up to 95: indexed from stack pointer.
// RL5: The zero test changes no status flag; it only reads and compares.
// RL6: Accumulator XOR with file or literal; literal form writes accumulator.
// RL7: File XOR destination bit 0 writes accumulator, 1 writes the file.
// RL8: File XOR decodes from 0001 10da and completes in one cycle.
// RL9: Both XOR forms update negative and zero flags only.
// RL10: Eight extra instructions exist, enabled at reset, gated by a fuse bit.
// RL11: Pointer add and subtract take one cycle except with select 11, and touch no flags.
// RL12: Pointer select 11 acts only on the stack pointer, in two cycles.
// RL13: Those stack pointer forms then return through the top of stack.
// RL14: Call via accumulator is word 0014h, two cycles, no flag change.
// RL15: Two-word indexed moves decode from 1110 1011; second word 1111.
// RL16: Push literal stores at the stack pointer, then decrements it.
// RL17: Add-and-return adds the literal, loads the program counter from stack.
// RL18: Call via accumulator pushes PC plus two, loads PC from pclatu, pclath and accumulator.
// RL19: Extension off: extended opcodes do nothing, low operands use access.
package xcore_pkg;
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_IWORD  = 8'h04;
  localparam logic [7:0] OFF_ACC    = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_BANK   = 8'h10;
  localparam logic [7:0] OFF_FSR0   = 8'h14;
  localparam logic [7:0] OFF_FSR1   = 8'h18;
  localparam logic [7:0] OFF_SPTR   = 8'h1C;
  localparam logic [7:0] OFF_PC     = 8'h20;
  localparam logic [7:0] OFF_RTOP   = 8'h24;
  localparam logic [7:0] OFF_LATCH  = 8'h28;
  localparam logic [7:0] OFF_CYC    = 8'h2C;
  localparam logic [7:0] OFF_MADDR  = 8'h30;
  localparam logic [7:0] OFF_MDATA  = 8'h34;
  localparam logic [7:0] OFF_CORE   = 8'h38;
  localparam logic       CTRL_RST   = 1'h1;
  localparam int         N_BIT      = 4;
  localparam int         Z_BIT      = 2;
  localparam logic [7:0] ACCESS_LIM = 8'h5F;
  localparam logic [3:0] ACCESS_HI  = 4'hF;
  localparam logic [6:0] OPC_TST    = 7'h33;
  localparam logic [7:0] OPC_XOR_LIT  = 8'h0A;
  localparam logic [5:0] OPC_XOR_FILE = 6'h06;
  localparam logic [7:0] OPC_ADDP   = 8'hE8;
  localparam logic [7:0] OPC_SUBP   = 8'hE9;
  localparam logic [7:0] OPC_PUSH_LIT = 8'hEA;
  localparam logic [7:0] OPC_MOV    = 8'hEB;
  localparam logic [3:0] OPC_WORD2  = 4'hF;
  localparam logic [15:0] OPC_CALL_ACC = 16'h0014;
  localparam logic [1:0] SEL_STACK  = 2'h3;
  localparam logic [1:0] EXTRA_TWO  = 2'h1;
  localparam logic [20:0] PC_STEP   = 21'h00_0002;

  typedef enum logic [1:0] {
    S_READY = 2'b01,
    S_STALL = 2'b10
  } core_state_t;

  typedef enum logic [3:0] {
    OP_NOP, OP_TST, OP_XOR_LIT, OP_XOR_FILE, OP_ADDP, OP_SUBP,
    OP_CALL_ACC, OP_MOV1, OP_PUSH_LIT
  } op_t;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [7:0]  data;
  } mem_wr_t;
endpackage

/* File: tb/cpu_xor_skip_and_ext_ops_decode_tb.sv */
// Self-checking bench driving the execution core over its register bus.
`timescale 1ns/1ps
`default_nettype none
module cpu_xor_skip_and_ext_ops_decode_tb;
  import xcore_pkg::*;
  logic        CLOCK;
  logic        NRST;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic        PREADY;
  logic [31:0] PRDATA;
  logic        PSLVERR;
  logic [3:0]  rom_idx;
  logic [15:0] rom_word;
  logic [31:0] rq;
  logic        re;
  logic [31:0] c0;
  int          num_errors;
  int          check_count;
  int          cyc;
  xcore xcore_inst (.CLOCK(CLOCK), .NRST(NRST), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR));
  prog_rom prog_rom_inst (.idx(rom_idx), .word(rom_word));
  always #20 CLOCK = ~CLOCK;
  task automatic finish_test;
    $display("errors=%0d checks=%0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    // The whole run needs a few hundred cycles; this only catches a hang.
    if (cyc == 20000)
    begin
      num_errors++;
      finish_test;
    end
  end
  // Ready is sampled at rising edges; the request is held until that edge.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    int n;
    n = 0;
    @(posedge CLOCK);
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'h1;
    @(posedge CLOCK);
    while (PREADY !== 1'h1 && n < 20)
    begin
      @(posedge CLOCK);
      n++;
    end
    if (n == 20)
      num_errors++;
    rq = PRDATA;
    re = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    check_count++;
    if (g !== x)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'h1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    xfer(1'h0, a, 32'h0000_0000);
    chk(rq, x);
  endtask
  task automatic mw(input logic [11:0] a, input logic [7:0] d);
    wr(OFF_MADDR, {20'h0_0000, a});
    wr(OFF_MDATA, {24'h00_0000, d});
  endtask
  task automatic mr(input logic [11:0] a, input logic [7:0] x);
    wr(OFF_MADDR, {20'h0_0000, a});
    rd(OFF_MDATA, {24'h00_0000, x});
  endtask
  task automatic ex(input logic [3:0] i);
    rom_idx = i;
    #1;
    wr(OFF_IWORD, {16'h0000, rom_word});
  endtask
  task automatic cyc_mark;
    xfer(1'h0, OFF_CYC, 32'h0000_0000);
    c0 = rq;
  endtask
  initial
  begin
    CLOCK = 1'h0;
    NRST = 1'h0;
    PSEL = 1'h0;
    PENABLE = 1'h0;
    PWRITE = 1'h0;
    PADDR = 8'h00;
    PWDATA = 32'h0000_0000;
    rom_idx = 4'h0;
    num_errors = 0;
    check_count = 0;
    cyc = 0;
    repeat (2) @(posedge CLOCK);
    NRST <= 1'h1;
    rd(OFF_CTRL, 32'h0000_0001);
    $display("test reset done");
    wr(OFF_ACC, 32'h0000_00B5);
    ex(4'h0);
    rd(OFF_ACC, 32'h0000_001A);
    rd(OFF_STATUS, 32'h0000_0000);
    ex(4'h1);
    rd(OFF_STATUS, 32'h0000_0004);
    wr(OFF_ACC, 32'h0000_00B5);
    mw(12'hF60, 8'hAF);
    ex(4'h2);
    mr(12'hF60, 8'h1A);
    rd(OFF_ACC, 32'h0000_00B5);
    $display("test xor done");
    wr(OFF_STATUS, 32'h0000_0014);
    wr(OFF_SPTR, 32'h0000_0100);
    mw(12'h110, 8'h00);
    mw(12'h010, 8'h01);
    cyc_mark;
    ex(4'h3);
    ex(4'h4);
    rd(OFF_CYC, c0 + 32'h0000_0002);
    rd(OFF_ACC, 32'h0000_00B5);
    rd(OFF_STATUS, 32'h0000_0014);
    wr(OFF_CTRL, 32'h0000_0000);
    ex(4'h3);
    ex(4'h4);
    rd(OFF_ACC, 32'h0000_004A);
    ex(4'h5);
    rd(OFF_SPTR, 32'h0000_0100);
    wr(OFF_CTRL, 32'h0000_0001);
    $display("test skip done");
    ex(4'h5);
    mr(12'h100, 8'h5A);
    rd(OFF_SPTR, 32'h0000_00FF);
    ex(4'h6);
    rd(OFF_SPTR, 32'h0000_0122);
    ex(4'h7);
    rd(OFF_SPTR, 32'h0000_00FF);
    wr(OFF_RTOP, 32'h0000_1234);
    cyc_mark;
    ex(4'h8);
    rd(OFF_SPTR, 32'h0000_0104);
    rd(OFF_PC, 32'h0000_1234);
    rd(OFF_CYC, c0 + 32'h0000_0002);
    $display("test pointer done");
    wr(OFF_PC, 32'h0000_0100);
    wr(OFF_LATCH, 32'h0000_0010);
    wr(OFF_ACC, 32'h0000_0006);
    wr(OFF_STATUS, 32'h0000_0014);
    cyc_mark;
    ex(4'h9);
    rd(OFF_PC, 32'h0000_1006);
    rd(OFF_RTOP, 32'h0000_0102);
    rd(OFF_CYC, c0 + 32'h0000_0002);
    rd(OFF_STATUS, 32'h0000_0014);
    wr(OFF_SPTR, 32'h0000_0200);
    mw(12'h203, 8'h77);
    ex(4'hA);
    ex(4'hB);
    mr(12'h345, 8'h77);
    wr(OFF_SPTR, 32'h0000_0100);
    cyc_mark;
    ex(4'h3);
    ex(4'hA);
    ex(4'hB);
    rd(OFF_CYC, c0 + 32'h0000_0003);
    $display("test call and move done");
    rd(8'h3C, 32'h0000_0000);
    chk({31'h0000_0000, re}, 32'h0000_0001);
    wr(8'h05, 32'h0000_00FF);
    chk({31'h0000_0000, re}, 32'h0000_0001);
    $display("test refusal done");
    finish_test;
  end
endmodule // cpu_xor_skip_and_ext_ops_decode_tb
`default_nettype wire

/* File: tb/prog_rom.sv */
// Program memory model that hands instruction words to the bench.
`timescale 1ns/1ps
`default_nettype none
module prog_rom
(
  input  wire logic [3:0]  idx,
  output var  logic [15:0] word
);
  always_comb
  begin
    case (idx)
      4'h0: word = 16'h0AAF;
      4'h1: word = 16'h0A1A;
      4'h2: word = 16'h1A60;
      4'h3: word = 16'h6610;
      4'h4: word = 16'h0AFF;
      4'h5: word = 16'hEA5A;
      4'h6: word = 16'hE8A3;
      4'h7: word = 16'hE9A3;
      4'h8: word = 16'hE8C5;
      4'h9: word = 16'h0014;
      4'hA: word = 16'hEB03;
      4'hB: word = 16'hF345;
      default: word = 16'h0000;
    endcase
  end
endmodule // prog_rom
`default_nettype wire

/* File: tb/xcore_checker.sv */
// Bus protocol and read-back checker for the execution core.
`timescale 1ns/1ps
`default_nettype none
module xcore_checker
  import xcore_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        NRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [7:0]  PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic        PREADY,
  input wire logic [31:0] PRDATA,
  input wire logic        PSLVERR
);
  logic bad;
  // Holes and unaligned offsets must be refused, never silently served.
  assign bad = (PADDR[1:0] != 2'h0) || (PADDR > OFF_CORE);
  default clocking dclk @(posedge CLOCK);
  endclocking
  default disable iff (!NRST);
  property p_pulse; PREADY |=> !PREADY; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_cause; PREADY |-> $past(PSEL && PENABLE); endproperty
  a_cause: assert property (p_cause) else $error("ready without access");
  property p_soon; $rose(PSEL && PENABLE) |-> ##[1:3] PREADY; endproperty
  a_soon: assert property (p_soon) else $error("ready too late");
  property p_idle; !PREADY |-> PRDATA == 32'h0000_0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside ready");
  property p_erronly; PSLVERR |-> PREADY; endproperty
  a_erronly: assert property (p_erronly) else $error("error without ready");
  property p_hole; PREADY && bad |-> PSLVERR; endproperty
  a_hole: assert property (p_hole) else $error("hole not refused");
  property p_mapped; PREADY && !bad |-> !PSLVERR; endproperty
  a_mapped: assert property (p_mapped) else $error("mapped access refused");
  property p_ctrl;
    PREADY && !PWRITE && PADDR == OFF_CTRL |-> PRDATA[31:1] == 31'h0000_0000;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control has stray bits");
  property p_pc;
    PREADY && !PWRITE && PADDR == OFF_PC |-> PRDATA[0] == 1'h0;
  endproperty
  a_pc: assert property (p_pc) else $error("program counter odd");
endmodule // xcore_checker
bind xcore xcore_checker xcore_checker_inst (.CLOCK(CLOCK), .NRST(NRST),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR));
`default_nettype wire
